// ### src/flash_access_defs.svh
// Constants for the flash external access and sector protection block
// What this block does
// - Reset with mode pins all high enters programming
// - Programming mode routes flash core signals to pins
// - Pins issue full program and erase commands
// - CPU mode holds width select high
// - CPU mode strobes come from internal control
// - Sector bits apply only with global protect set
// - Bit zero protects its 8 KB sector
// - Decode 8 KB and 64 KB sector pairs
`ifndef FLASH_ACCESS_DEFS_SVH
`define FLASH_ACCESS_DEFS_SVH
`define MODE_PROG_STRAP      3'h7
`define SV_GLOBAL_PROT_BIT   17
`define SV_SECTOR_BITS       8
`define SMALL_SECT_BASE      22'h140000
`define SMALL_SECT_END       22'h150000
`define SMALL_SECT_SIZE_SH   14
`define BIG_SECT_BASE        22'h040000
`define BIG_SECT_SIZE_SH     17
`define BIG_SECT_END         22'h140000
`endif

// ### src/flash_access_pkg.sv
// Types for the flash external access block
package flash_access_pkg;
    typedef enum logic [1:0] {SEL_NONE, SEL_SMALL, SEL_BIG} sect_kind_t;
endpackage

// ### src/flash_access.sv
// Flash core access mux between CPU and parallel programming pins
`timescale 1ns/1ns
`include "flash_access_defs.svh"
module flash_access
    import flash_access_pkg::*;
#(
    parameter int ADDR_W = 22
)(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [2:0]        mode_select_pins_i,
    input  wire logic              cpu_we_n_i,
    input  wire logic              cpu_oe_n_i,
    input  wire logic              cpu_ce_n_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic [15:0]       cpu_wdata_i,
    input  wire logic              cpu_core_rst_n_i,
    input  wire logic              flash_core_reset_n_i,
    input  wire logic              width_select_n_i,
    input  wire logic              flash_write_strobe_n_i,
    input  wire logic              flash_output_enable_n_i,
    input  wire logic              flash_chip_enable_n_i,
    input  wire logic [ADDR_W-1:0] pin_addr_i,
    input  wire logic [15:0]       pin_dq_i,
    input  wire logic [15:0]       core_rdata_i,
    input  wire logic              core_ready_i,
    input  wire logic [31:0]       security_vector_word_one_i,
    output logic                   prog_mode_o,
    output logic                   cpu_halt_o,
    output logic                   core_rst_n_o,
    output logic                   core_width_n_o,
    output logic                   core_we_n_o,
    output logic                   core_oe_n_o,
    output logic                   core_ce_n_o,
    output logic [ADDR_W-1:0]      core_addr_o,
    output logic [15:0]            core_wdata_o,
    output logic [15:0]            pin_dq_o,
    output logic                   pin_dq_oe_o,
    output logic                   flash_ready_busy_n_o,
    output logic                   flash_ctrl_ready_flag_o,
    output logic                   sector_protected_o,
    output logic                   write_blocked_o,
    output logic [1:0]             sector_kind_o,
    output logic [4:0]             sector_index_o
);
    logic              strap_q;
    logic              strap_d;
    logic [7:0]        prot_bits;
    logic [7:0]        prot_vec;
    logic              glob_prot;
    logic [ADDR_W-1:0] sel_addr;
    logic              sel_we_n;
    logic              sel_oe_n;
    logic              sel_ce_n;
    logic              sel_rst_n;
    logic              sel_width_n;
    logic [15:0]       sel_wdata;
    logic              in_small;
    logic              in_big;
    logic [2:0]        small_idx;
    logic [4:0]        big_idx;
    logic [4:0]        sect_idx;
    logic              prot_hit;
    logic              dq_drive;
    logic              busy_pin;
    logic              blocked;
    sect_kind_t        kind;
    logic              half_sel;

    // Strap is caught on the clock while reset is held
    assign strap_d = sys_rst_i ? (mode_select_pins_i == `MODE_PROG_STRAP) : strap_q;

    always_ff @(posedge clk_i)
    begin
        strap_q <= strap_d;
    end

    // Source selection between CPU and pins
    assign sel_addr    = strap_q ? pin_addr_i : cpu_addr_i;
    assign sel_we_n    = strap_q ? flash_write_strobe_n_i : cpu_we_n_i;
    assign sel_oe_n    = strap_q ? flash_output_enable_n_i : cpu_oe_n_i;
    assign sel_ce_n    = strap_q ? flash_chip_enable_n_i : cpu_ce_n_i;
    assign sel_rst_n   = strap_q ? flash_core_reset_n_i : cpu_core_rst_n_i;
    assign sel_width_n = strap_q ? width_select_n_i : 1'b1;
    assign sel_wdata   = strap_q ? pin_dq_i : cpu_wdata_i;

    // Sector decode; address bit one picks the half of a pair
    assign half_sel  = sel_addr[1];
    assign in_small  = (sel_addr >= `SMALL_SECT_BASE) && (sel_addr < `SMALL_SECT_END);
    assign in_big    = (sel_addr >= `BIG_SECT_BASE) && (sel_addr < `BIG_SECT_END);
    assign small_idx = {sel_addr[15:14], half_sel};
    assign big_idx   = 5'(5'd8 + {(sel_addr[ADDR_W-1:17] - 5'd2), 1'b0} + {4'h0, half_sel});
    assign sect_idx  = in_small ? {2'b00, small_idx} : (in_big ? big_idx : 5'h00);
    assign kind      = in_small ? SEL_SMALL : (in_big ? SEL_BIG : SEL_NONE);

    // Per-sector protection gated by the global bit
    assign glob_prot = security_vector_word_one_i[`SV_GLOBAL_PROT_BIT];
    assign prot_bits = security_vector_word_one_i[`SV_SECTOR_BITS-1:0];

    generate
        for (genvar g = 0; g < `SV_SECTOR_BITS; g++)
        begin : g_prot
            assign prot_vec[g] = glob_prot && !prot_bits[g] && (small_idx == 3'(g));
        end
    endgenerate

    assign prot_hit = in_small && (|prot_vec);
    assign blocked  = prot_hit && !sel_we_n;

    // Pin side drive and ready
    assign dq_drive = strap_q && !flash_output_enable_n_i && !flash_chip_enable_n_i;
    assign busy_pin = strap_q ? core_ready_i : 1'b1;

    // Mode outputs
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            prog_mode_o <= 1'b0;
            cpu_halt_o  <= 1'b1;
        end
        else
        begin
            prog_mode_o <= strap_q;
            cpu_halt_o  <= strap_q;
        end
    end

    // Core strobes
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            core_rst_n_o   <= 1'b0;
            core_width_n_o <= 1'b1;
            core_we_n_o    <= 1'b1;
            core_oe_n_o    <= 1'b1;
            core_ce_n_o    <= 1'b1;
        end
        else
        begin
            core_rst_n_o   <= sel_rst_n;
            core_width_n_o <= sel_width_n;
            core_we_n_o    <= sel_we_n | prot_hit;
            core_oe_n_o    <= sel_oe_n;
            core_ce_n_o    <= sel_ce_n;
        end
    end

    // Core address and write data
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            core_addr_o  <= '0;
            core_wdata_o <= 16'h0000;
        end
        else
        begin
            core_addr_o  <= sel_addr;
            core_wdata_o <= sel_wdata;
        end
    end

    // Data pins back to the programmer
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_dq_o    <= 16'h0000;
            pin_dq_oe_o <= 1'b0;
        end
        else
        begin
            pin_dq_o    <= core_rdata_i;
            pin_dq_oe_o <= dq_drive;
        end
    end

    // Ready indications
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            flash_ready_busy_n_o    <= 1'b1;
            flash_ctrl_ready_flag_o <= 1'b1;
        end
        else
        begin
            flash_ready_busy_n_o    <= busy_pin;
            flash_ctrl_ready_flag_o <= core_ready_i;
        end
    end

    // Protection and sector status
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sector_protected_o <= 1'b0;
            write_blocked_o    <= 1'b0;
            sector_kind_o      <= 2'h0;
            sector_index_o     <= 5'h00;
        end
        else
        begin
            sector_protected_o <= prot_hit;
            write_blocked_o    <= blocked;
            sector_kind_o      <= kind;
            sector_index_o     <= sect_idx;
        end
    end
endmodule

// ### test/flash_access_props.sv
// Checker for the flash access block
`timescale 1ns/1ns
module flash_access_props (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        cpu_ce_n_i,
    input wire logic        core_ready_i,
    input wire logic        prog_mode_o,
    input wire logic        core_width_n_o,
    input wire logic        core_ce_n_o,
    input wire logic        core_we_n_o,
    input wire logic        flash_ready_busy_n_o,
    input wire logic        write_blocked_o,
    input wire logic [21:0] pin_addr_i,
    input wire logic [21:0] core_addr_o,
    input wire logic [31:0] security_vector_word_one_i,
    input wire logic [1:0]  sector_kind_o,
    input wire logic [4:0]  sector_index_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_mode_held: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> $stable(prog_mode_o))
        else $error("mode moved");
    a_pin_route: assert property (prog_mode_o && !$past(sys_rst_i) |-> core_addr_o == $past(pin_addr_i))
        else $error("pin address lost");
    a_width_high: assert property (!prog_mode_o |-> core_width_n_o) else $error("width low");
    a_cpu_strobe: assert property (!prog_mode_o && !$past(sys_rst_i) |-> core_ce_n_o == $past(cpu_ce_n_i))
        else $error("chip enable lost");
    a_block_cause: assert property (write_blocked_o |-> core_we_n_o && $past(security_vector_word_one_i[17]))
        else $error("bad block");
    a_small_index: assert property (sector_kind_o == 2'h1 |-> sector_index_o == {core_addr_o[15:14], core_addr_o[1]})
        else $error("bad index");
    a_small_area: assert property (!$past(sys_rst_i) |-> (sector_kind_o == 2'h1) == (core_addr_o[21:16] == 6'h14))
        else $error("bad area");
    a_busy_follow: assert property (!$past(sys_rst_i) |-> flash_ready_busy_n_o == (!prog_mode_o | $past(core_ready_i)))
        else $error("bad busy");
endmodule

// ### test/prog_pins_model.sv
// Parallel programmer pin model
`timescale 1ns/1ns
module prog_pins_model (
    input  wire logic        big_i, glob_i,
    input  wire logic [21:0] addr_i,
    output logic      [21:0] pin_addr_o,
    output logic      [31:0] sv_o
);
    assign pin_addr_o = {big_i | addr_i[21], big_i ? addr_i[20] : 1'b1, addr_i[19:1], 1'b0};
    assign sv_o = {14'h0, glob_i, 17'h0ffef};
endmodule

// ### test/tb_flash_access.sv
// Testbench for the flash access block
`timescale 1ns/1ns
module tb_flash_access;
    logic clk_i = 0, sys_rst_i, cpu_we_n_i, cpu_oe_n_i, cpu_ce_n_i, cpu_core_rst_n_i, flash_core_reset_n_i;
    logic width_select_n_i, flash_write_strobe_n_i, flash_output_enable_n_i, flash_chip_enable_n_i, core_ready_i;
    logic prog_mode_o, cpu_halt_o, core_rst_n_o, core_width_n_o, core_we_n_o, core_oe_n_o, core_ce_n_o, glob, big;
    logic pin_dq_oe_o, flash_ready_busy_n_o, flash_ctrl_ready_flag_o, sector_protected_o, write_blocked_o, we, wb;
    logic [2:0] mode_select_pins_i;
    logic [1:0] sector_kind_o;
    logic [4:0] sector_index_o;
    logic [15:0] cpu_wdata_i, pin_dq_i, core_rdata_i, core_wdata_o, pin_dq_o;
    logic [21:0] cpu_addr_i, pin_addr_i, core_addr_o, pa;
    logic [31:0] security_vector_word_one_i, seed = 32'h468c1eaa;
    int miscompares = 0, checks = 0;
    always #4 clk_i = ~clk_i;
    flash_access i_dut (.*);
    prog_pins_model i_model (.big_i(big), .glob_i(glob), .addr_i(cpu_addr_i), .pin_addr_o(pin_addr_i),
        .sv_o(security_vector_word_one_i));
    function automatic logic [4:0] exp_index(logic [21:0] a);
        if (a[21:16] == 6'h14)
            return {2'b00, a[15:14], a[1]};
        if (a >= 22'h40000 && a < 22'h140000)
            return 5'(5'd8 + {(a[21:17] - 5'd2), 1'b0} + {4'h0, a[1]});
        return 5'h00;
    endfunction
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(logic [21:0] got, logic [21:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %0t %h %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #10000;
        miscompares++;
        report_and_stop;
    end
    initial
    begin
        for (int ph = 0; ph < 2; ph++)
            for (int i = 0; i < 300; i++)
            begin
                seed = lfsr(seed);
                {cpu_we_n_i, flash_write_strobe_n_i, cpu_ce_n_i, flash_chip_enable_n_i, core_ready_i} = seed[4:0];
                {glob, big, width_select_n_i, mode_select_pins_i} = seed[10:5];
                {cpu_oe_n_i, flash_output_enable_n_i, cpu_core_rst_n_i, flash_core_reset_n_i} = seed[25:22];
                cpu_addr_i = {seed[11] ? 6'h14 : seed[21:16], seed[15:0]};
                {pin_dq_i, cpu_wdata_i, core_rdata_i} = {seed, seed[15:0]};
                sys_rst_i = i < 4;
                if (sys_rst_i)
                    mode_select_pins_i = ph ? 3'h3 : 3'h7;
                @(negedge clk_i);
                pa = ph ? cpu_addr_i : pin_addr_i;
                we = ph ? cpu_we_n_i : flash_write_strobe_n_i;
                wb = glob & ~we & (pa[21:16] == 6'h14) & ({pa[15:14], pa[1]} == 3'h4);
                if (i >= 4)
                begin
                    chk(prog_mode_o, !ph);
                    chk(core_addr_o, pa);
                    chk(core_wdata_o, ph ? cpu_wdata_i : pin_dq_i);
                    chk(core_width_n_o, ph | width_select_n_i);
                    chk(core_ce_n_o, ph ? cpu_ce_n_i : flash_chip_enable_n_i);
                    chk({write_blocked_o, core_we_n_o}, {wb, we | wb});
                    chk(sector_kind_o, pa[21:16] == 6'h14 ? 1 : (pa >= 22'h40000 && pa < 22'h140000) ? 2 : 0);
                    chk(flash_ready_busy_n_o, ph | core_ready_i);
                    chk(flash_ctrl_ready_flag_o, core_ready_i);
                    chk(cpu_halt_o, !ph);
                    chk(core_rst_n_o, ph ? cpu_core_rst_n_i : flash_core_reset_n_i);
                    chk(core_oe_n_o, ph ? cpu_oe_n_i : flash_output_enable_n_i);
                    chk(pin_dq_oe_o, !ph & !flash_output_enable_n_i & !flash_chip_enable_n_i);
                    chk(pin_dq_o, core_rdata_i);
                    chk(sector_protected_o, glob & (pa[21:16] == 6'h14) & ({pa[15:14], pa[1]} == 3'h4));
                    chk(sector_index_o, exp_index(pa));
                end
            end
        report_and_stop;
    end
endmodule
bind flash_access flash_access_props i_props (.*);
